// ---- verilog/tilt_input_controller.sv ----
// tilt switch input: timed display lock or special function input
`timescale 1ns/10ps
module tilt_input_controller
	import tilt_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
)(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [SET_W-1:0] setting_i,
	input wire logic contact_i,
	input wire logic tare_done_i,
	input wire logic tare_ok_i,
	output logic display_lock_o,
	output req_t req_o,
	output logic setpoint_en_o,
	output logic scale_sel_o
);
	logic sync1;
	logic sync2;
	logic level_d;
	logic [SET_W-1:0] elapsed;
	logic tare_pend;
	logic tare_won;
	logic tick;
	mode_t mode;

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			level_d <= 1'b0;
		end
		else
		begin
			sync1 <= contact_i;
			sync2 <= sync1;
			level_d <= sync2;
		end
	end

	wire rise = sync2 && !level_d;

	tick_divider #(
		.DIV(TICK_DIV)
	) u_tick (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.tick_o(tick)
	);

	always_comb
	begin
		unique case (setting_i)
			SET_OFF: mode = MODE_OFF;
			FN_TARE: mode = MODE_TARE;
			FN_PRINT: mode = MODE_PRINT;
			FN_GATE: mode = MODE_GATE;
			FN_TARE_GATE: mode = MODE_TARE_GATE;
			FN_SCALE: mode = MODE_SCALE;
			FN_ZERO: mode = MODE_ZERO;
			default: mode = (setting_i <= DELAY_MAX) ? MODE_LOCK : MODE_OFF;
		endcase
	end

	// in lock mode, lock wants to change whenever the stable level differs from it
	wire lock_mode = (mode == MODE_LOCK);
	wire differs = lock_mode && (sync2 != display_lock_o);
	wire done = differs && tick && ((elapsed + 1'b1) >= setting_i);

	// count 100 ms ticks, so the first unit may be partial; a bounce restarts the wait
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i || !differs || done)
			elapsed <= '0;
		else if (tick)
			elapsed <= elapsed + 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i || !lock_mode)
			display_lock_o <= 1'b0;
		else if (done)
			display_lock_o <= sync2;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			req_o <= '0;
		else
		begin
			req_o.tare_req <= rise && (mode == MODE_TARE || mode == MODE_TARE_GATE);
			req_o.print_req <= rise && (mode == MODE_PRINT);
			req_o.zero_req <= rise && (mode == MODE_ZERO);
		end
	end

	// waiting for tare result while input stays high
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i || mode != MODE_TARE_GATE || !sync2)
			tare_pend <= 1'b0;
		else if (req_o.tare_req)
			tare_pend <= 1'b1;
		else if (tare_done_i)
			tare_pend <= 1'b0;
	end

	// a tare that finished well while one was outstanding
	wire tare_hit = tare_pend && tare_done_i && tare_ok_i;

	// good tare remembered; entering the mode with input high must not
	// carry over setpoints that another setting had left on
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i || mode != MODE_TARE_GATE || !sync2)
			tare_won <= 1'b0;
		else if (tare_hit)
			tare_won <= 1'b1;
	end

	// setpoint gating; outside these modes setpoints stay enabled
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			setpoint_en_o <= 1'b1;
		else if (mode == MODE_GATE)
			setpoint_en_o <= sync2;
		else if (mode == MODE_TARE_GATE)
			setpoint_en_o <= sync2 && (tare_won || tare_hit);
		else
			setpoint_en_o <= 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			scale_sel_o <= 1'b0;
		else
			scale_sel_o <= (mode == MODE_SCALE) && sync2;
	end

	// contact seen low once, then high on three samples in a row
	sequence contact_rises_s;
		!contact_i ##1 contact_i [*3];
	endsequence

	// good tare arriving while the input is still high in tare-gate mode
	sequence good_tare_s;
		mode == MODE_TARE_GATE && sync2 && tare_hit;
	endsequence

	// lock rises only with a completed wait
	lock_rise_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(display_lock_o) |-> $past(done) && $past(sync2))
		else $error("lock set without elapsed delay");
	lock_fall_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$fell(display_lock_o) && $past(lock_mode) |-> $past(done))
		else $error("lock released early");
	lock_off_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		mode != MODE_LOCK |=> !display_lock_o)
		else $error("lock asserted outside lock mode");
	tare_pulse_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rise && mode == MODE_TARE |=> req_o.tare_req ##1 !req_o.tare_req)
		else $error("tare request not a single pulse");
	print_pulse_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rise && mode == MODE_PRINT |=> req_o.print_req)
		else $error("print request missing");
	gate_level_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		mode == MODE_GATE |=> setpoint_en_o == $past(sync2))
		else $error("setpoint gate wrong");
	tare_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		mode == MODE_TARE_GATE && !sync2 |=> !setpoint_en_o)
		else $error("setpoints on while input low");
	scale_sel_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		mode == MODE_SCALE |=> scale_sel_o == $past(sync2))
		else $error("scale select wrong");
	zero_req_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rise && mode == MODE_ZERO |=> req_o.zero_req)
		else $error("zero request missing");
	// edge seen two cycles after input rise held
	sync_edge_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		contact_rises_s |-> rise)
		else $error("edge detect latency wrong");
	// lock moves only on a delay tick
	lock_tick_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$past(lock_mode) && $changed(display_lock_o) |-> $past(tick))
		else $error("lock changed between ticks");
	// a bounce back restarts the wait
	wait_restart_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		lock_mode && !differs |=> elapsed == '0)
		else $error("wait not restarted");
	// special settings never run the timed lock
	special_lock_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		setting_i > DELAY_MAX |=> !display_lock_o)
		else $error("lock active on special setting");
	// tare and print settings keep setpoints on
	sp_always_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(mode == MODE_TARE || mode == MODE_PRINT) |=> setpoint_en_o)
		else $error("setpoints off in tare or print setting");
	tare_ok_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		good_tare_s |=> setpoint_en_o)
		else $error("setpoints not on after good tare");
	// in tare-gate mode, without a good tare setpoints stay off
	tare_only_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		mode == MODE_TARE_GATE && !tare_won && !tare_hit |=> !setpoint_en_o)
		else $error("setpoints on without good tare");
endmodule

// ---- verilog/tilt_pkg.sv ----
// shared constants and types for the tilt input controller
package tilt_pkg;
	localparam int CLK_HZ = 10000000;
	localparam int TICK_MS = 100;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int SET_W = 7;
	localparam logic [6:0] SET_OFF = 7'h00;
	localparam logic [6:0] DELAY_MAX = 7'h5a;
	localparam logic [6:0] FN_TARE = 7'h5b;
	localparam logic [6:0] FN_PRINT = 7'h5c;
	localparam logic [6:0] FN_GATE = 7'h5d;
	localparam logic [6:0] FN_TARE_GATE = 7'h5e;
	localparam logic [6:0] FN_SCALE = 7'h5f;
	localparam logic [6:0] FN_ZERO = 7'h60;

	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_LOCK,
		MODE_TARE,
		MODE_PRINT,
		MODE_GATE,
		MODE_TARE_GATE,
		MODE_SCALE,
		MODE_ZERO
	} mode_t;

	typedef struct packed {
		logic tare_req;
		logic print_req;
		logic zero_req;
	} req_t;
endpackage

// ---- verilog/tick_divider.sv ----
// prescaler producing the 100 ms tick enable
`timescale 1ns/10ps
module tick_divider
	import tilt_pkg::*;
#(
	parameter int DIV = TICK_CYCLES
)(
	input wire logic clk_i,
	input wire logic rstn_i,
	output logic tick_o
);
	logic [$clog2(DIV)-1:0] count;
	wire last = (count == ($clog2(DIV))'(DIV - 1));

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			count <= '0;
		else if (last)
			count <= '0;
		else
			count <= count + 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			tick_o <= 1'b0;
		else
			tick_o <= last;
	end
endmodule

// ---- testbench/tilt_contact_model.sv ----
// behavioural tilt switch contact facing the digital input
`timescale 1ns/10ps
module tilt_contact_model
(
	input wire logic clk_i,
	input wire logic closed_i,
	output logic contact_o
);
	initial contact_o = 1'b0;
	// contact moves just after an edge, never on the sampling instant
	always @(posedge clk_i)
		contact_o <= #1 closed_i;
endmodule

// ---- testbench/test_tilt_input_controller.sv ----
// self-checking bench for the tilt input controller
`timescale 1ns/10ps
module test_tilt_input_controller;
	import tilt_pkg::*;
	logic clk_i = 0, rstn_i = 0, closed = 0, contact, tare_done_i = 0, tare_ok_i = 0;
	logic [SET_W-1:0] setting_i = SET_OFF;
	logic display_lock_o, setpoint_en_o, scale_sel_o;
	req_t req_o, last = 3'h0;
	int err_count = 0, n_tests = 0, seed = 64, n_pulse = 0, d;
	tilt_contact_model u_tilt_contact_model(.clk_i(clk_i), .closed_i(closed), .contact_o(contact));
	tilt_input_controller #(.TICK_DIV(10)) u_tilt_input_controller(.clk_i(clk_i),
		.rstn_i(rstn_i), .setting_i(setting_i), .contact_i(contact), .tare_done_i(tare_done_i),
		.tare_ok_i(tare_ok_i), .display_lock_o(display_lock_o), .req_o(req_o),
		.setpoint_en_o(setpoint_en_o), .scale_sel_o(scale_sel_o));
	initial
	begin
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		if (|req_o)
		begin
			n_pulse++;
			last = req_o;
		end
	end
	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	function automatic logic exp_sp(logic [6:0] s, logic v);
		return (s == FN_GATE || s == FN_TARE_GATE) ? v : 1'b1;
	endfunction
	function automatic req_t exp_req(logic [6:0] s);
		if (s == FN_TARE || s == FN_TARE_GATE)
			return 3'h4;
		if (s == FN_PRINT)
			return 3'h2;
		return (s == FN_ZERO) ? 3'h1 : 3'h0;
	endfunction
	task conclude;
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#2000000;
		err_count++;
		conclude();
	end
	initial
	begin
		cyc(5);
		rstn_i = 1;
		cyc(1);
		check("lock_rst", display_lock_o, 0);
		check("sp_rst", setpoint_en_o, 1);
		repeat (3)
		begin
			d = 1 + ($unsigned($random(seed)) % 5);
			setting_i = d[6:0];
			for (int v = 1; v >= 0; v--)
			begin
				closed = v[0];
				cyc((d - 1) * 10 + 2);
				check("lock_early", display_lock_o, !v[0]);
				cyc(14);
				check("lock_late", display_lock_o, v[0]);
			end
		end
		setting_i = SET_OFF;
		closed = 1;
		cyc(40);
		check("lock_off", display_lock_o, 0);
		for (logic [6:0] s = FN_TARE; s <= FN_ZERO; s++)
		begin
			setting_i = s;
			closed = 0;
			cyc(8);
			n_pulse = 0;
			last = 3'h0;
			closed = 1;
			cyc(8);
			check("req", last, exp_req(s));
			check("n_req", n_pulse[7:0], exp_req(s) != 0);
			check("lock_fn", display_lock_o, 0);
			check("sp_hi", setpoint_en_o, exp_sp(s, 1) && s != FN_TARE_GATE);
			check("scale_hi", scale_sel_o, s == FN_SCALE);
			if (s == FN_TARE_GATE)
			begin
				setting_i = FN_PRINT;
				cyc(3);
				setting_i = FN_TARE_GATE;
				cyc(2);
				check("sp_entry", setpoint_en_o, 0);
				for (int ok = 0; ok < 2; ok++)
				begin
					closed = 0;
					cyc(6);
					closed = 1;
					cyc(8);
					tare_done_i = 1;
					tare_ok_i = ok[0];
					cyc(1);
					tare_done_i = 0;
					cyc(2);
					check("sp_tare", setpoint_en_o, ok[0]);
				end
			end
			closed = 0;
			cyc(6);
			check("sp_lo", setpoint_en_o, exp_sp(s, 0));
			check("scale_lo", scale_sel_o, 0);
		end
		conclude();
	end
endmodule
